// ### src/llcr_regs.sv
// link core control and status register bank with cipher start, test tallies and timer compares
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
module llcr_regs (
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // register port
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // link engine events and base time
  input wire llcr_pkg::llcr_evt_s i_evt,
  input wire logic [26:0] i_base_time_counter,
  // configuration, cipher status and timer hits to the link engine
  output llcr_pkg::llcr_cfg_s o_cfg,
  output logic [15:0] o_payload_len,
  output logic o_cipher_start,
  output logic o_cipher_busy,
  output logic [31:0] o_diag_profile,
  output logic o_coarse_hit,
  output logic o_fine_hit,
  output logic [4:0] o_rtrip_cycles_hi
);

  typedef struct packed {
    llcr_pkg::llcr_cfg_s cfg;
    llcr_pkg::llcr_ciph_e ciph;
    logic busy;
    logic start_pulse;
    logic late_err;
    logic [31:0] tx_mic;
    logic [31:0] rx_mic;
    logic [31:0] tx_run;
    logic [31:0] rx_run;
    logic [31:0] tx_tally;
    logic [31:0] rx_tally;
    logic [8:0] scan_scan_init_a;
    logic [8:0] scan_upper;
    logic coarse_hit;
    logic fine_hit;
    logic [26:0] time_sample;
    logic [31:0] rdata;
  } llcr_state_s;

  llcr_state_s st_q;
  llcr_state_s st_d;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic llcr_pkg::llcr_cfg_s cfg_reset();
    llcr_pkg::llcr_cfg_s c;
    c = '0;
    c.rx_pwrup = llcr_pkg::PWRUP_RST;
    c.tx_pwrup = llcr_pkg::PWRUP_RST;
    c.tx_pwrdn = llcr_pkg::PWRDN_RST;
    c.adv_map = llcr_pkg::ADV_MAP_RST;
    c.fetch_at = llcr_pkg::FETCH_RST;
    c.abort_at = llcr_pkg::ABORT_RST;
    c.early_abort = llcr_pkg::EARLY_ABORT_RST;
    cfg_reset = c;
  endfunction : cfg_reset

  function automatic logic [31:0] read_mux(input llcr_state_s s, input logic [31:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (hit(a, llcr_pkg::OFS_ERROR_STAT)) r = {31'h0, s.late_err};
    if (hit(a, llcr_pkg::OFS_PROFILE)) r = s.cfg.profile;
    if (hit(a, llcr_pkg::OFS_RADIO_SEL)) r[20:16] = s.cfg.radio_sel;
    if (hit(a, llcr_pkg::OFS_PWR_TIMING)) begin
      r[30:24] = s.cfg.rtrip;
      r[23:16] = s.cfg.rx_pwrup;
      r[11:8] = s.cfg.tx_pwrdn;
      r[7:0] = s.cfg.tx_pwrup;
    end
    if (hit(a, llcr_pkg::OFS_ADV_MAP)) r[2:0] = s.cfg.adv_map;
    if (hit(a, llcr_pkg::OFS_ADV_INTERVAL)) r[13:0] = s.cfg.adv_space;
    if (hit(a, llcr_pkg::OFS_SCAN_COUNTERS)) begin
      r[24:16] = s.scan_scan_init_a;
      r[8:0] = s.scan_upper;
    end
    if (hit(a, llcr_pkg::OFS_PUB_LIST)) r[15:0] = s.cfg.pub_start;
    if (hit(a, llcr_pkg::OFS_PRIV_LIST)) r[15:0] = s.cfg.priv_start;
    if (hit(a, llcr_pkg::OFS_LIST_COUNTS)) r[15:0] = {s.cfg.priv_cnt, s.cfg.pub_cnt};
    if (hit(a, llcr_pkg::OFS_CIPHER_CTRL)) r[1] = s.cfg.cipher_mode;
    if (hit(a, llcr_pkg::OFS_KEY0)) r = s.cfg.key[31:0];
    if (hit(a, llcr_pkg::OFS_KEY1)) r = s.cfg.key[63:32];
    if (hit(a, llcr_pkg::OFS_KEY2)) r = s.cfg.key[95:64];
    if (hit(a, llcr_pkg::OFS_KEY3)) r = s.cfg.key[127:96];
    if (hit(a, llcr_pkg::OFS_CIPHER_PTR)) r[15:0] = s.cfg.cipher_addr;
    if (hit(a, llcr_pkg::OFS_TX_MIC)) r = s.tx_mic;
    if (hit(a, llcr_pkg::OFS_RX_MIC)) r = s.rx_mic;
    if (hit(a, llcr_pkg::OFS_TEST_CTRL)) begin
      r[31] = s.cfg.endless_rx;
      r[27] = s.cfg.rx_cnt_en;
      r[15] = s.cfg.endless_tx;
      r[14] = s.cfg.len_src;
      r[13] = s.cfg.prbs_type;
      r[12] = s.cfg.pld_src;
      r[11] = s.cfg.tx_cnt_en;
      r[8:0] = s.cfg.test_len;
    end
    if (hit(a, llcr_pkg::OFS_TEST_TX_CNT)) r = s.tx_tally;
    if (hit(a, llcr_pkg::OFS_TEST_RX_CNT)) r = s.rx_tally;
    if (hit(a, llcr_pkg::OFS_PREFETCH)) begin
      r[31] = s.cfg.early_abort;
      r[25:16] = s.cfg.abort_at;
      r[8:0] = s.cfg.fetch_at;
    end
    if (hit(a, llcr_pkg::OFS_COARSE_TGT)) r[22:0] = s.cfg.coarse_tgt;
    if (hit(a, llcr_pkg::OFS_FINE_TGT)) r[26:0] = s.cfg.fine_tgt;
    if (hit(a, llcr_pkg::OFS_SAMPLE)) r[26:0] = s.time_sample;
    read_mux = r;
  endfunction : read_mux

  always_comb begin
    st_d = st_q;
    st_d.start_pulse = 1'b0;
    if (i_wr) begin
      if (hit(i_addr, llcr_pkg::OFS_PROFILE)) st_d.cfg.profile = i_wdata;
      if (hit(i_addr, llcr_pkg::OFS_RADIO_SEL)) st_d.cfg.radio_sel = i_wdata[20:16];
      if (hit(i_addr, llcr_pkg::OFS_PWR_TIMING)) begin
        st_d.cfg.rtrip = i_wdata[30:24];
        st_d.cfg.rx_pwrup = i_wdata[23:16];
        st_d.cfg.tx_pwrdn = i_wdata[11:8];
        st_d.cfg.tx_pwrup = i_wdata[7:0];
      end
      if (hit(i_addr, llcr_pkg::OFS_ADV_MAP)) st_d.cfg.adv_map = i_wdata[2:0];
      if (hit(i_addr, llcr_pkg::OFS_ADV_INTERVAL)) st_d.cfg.adv_space = i_wdata[13:0];
      if (hit(i_addr, llcr_pkg::OFS_PUB_LIST)) st_d.cfg.pub_start = i_wdata[15:0];
      if (hit(i_addr, llcr_pkg::OFS_PRIV_LIST)) st_d.cfg.priv_start = i_wdata[15:0];
      if (hit(i_addr, llcr_pkg::OFS_LIST_COUNTS)) begin
        st_d.cfg.priv_cnt = i_wdata[15:8];
        st_d.cfg.pub_cnt = i_wdata[7:0];
      end
      if (hit(i_addr, llcr_pkg::OFS_CIPHER_CTRL)) begin
        // mode is held while a block is in flight so the engine sees one direction
        if (st_q.ciph == llcr_pkg::CIPH_IDLE) begin
          st_d.cfg.cipher_mode = i_wdata[1];
          if (i_wdata[0]) begin
            st_d.ciph = llcr_pkg::CIPH_FETCH;
            st_d.start_pulse = 1'b1;
          end
        end
      end
      if (hit(i_addr, llcr_pkg::OFS_KEY0)) st_d.cfg.key[31:0] = i_wdata;
      if (hit(i_addr, llcr_pkg::OFS_KEY1)) st_d.cfg.key[63:32] = i_wdata;
      if (hit(i_addr, llcr_pkg::OFS_KEY2)) st_d.cfg.key[95:64] = i_wdata;
      if (hit(i_addr, llcr_pkg::OFS_KEY3)) st_d.cfg.key[127:96] = i_wdata;
      if (hit(i_addr, llcr_pkg::OFS_CIPHER_PTR)) st_d.cfg.cipher_addr = i_wdata[15:0];
      if (hit(i_addr, llcr_pkg::OFS_TEST_CTRL)) begin
        st_d.cfg.endless_rx = i_wdata[31];
        st_d.cfg.rx_cnt_en = i_wdata[27];
        st_d.cfg.endless_tx = i_wdata[15];
        st_d.cfg.len_src = i_wdata[14];
        st_d.cfg.prbs_type = i_wdata[13];
        st_d.cfg.pld_src = i_wdata[12];
        st_d.cfg.tx_cnt_en = i_wdata[11];
        st_d.cfg.test_len = i_wdata[8:0];
      end
      if (hit(i_addr, llcr_pkg::OFS_PREFETCH)) begin
        st_d.cfg.early_abort = i_wdata[31];
        st_d.cfg.abort_at = i_wdata[25:16];
        st_d.cfg.fetch_at = i_wdata[8:0];
      end
      if (hit(i_addr, llcr_pkg::OFS_COARSE_TGT)) st_d.cfg.coarse_tgt = i_wdata[22:0];
      if (hit(i_addr, llcr_pkg::OFS_FINE_TGT)) st_d.cfg.fine_tgt = i_wdata[26:0];
      // sample bit is write-one, self clearing: capture immediately
      if (hit(i_addr, llcr_pkg::OFS_SAMPLE) && i_wdata[0]) st_d.time_sample = i_base_time_counter;
    end
    // cipher sequence: fetch then run until completion
    unique case (st_q.ciph)
      llcr_pkg::CIPH_IDLE: begin
      end
      llcr_pkg::CIPH_FETCH: begin
        st_d.ciph = llcr_pkg::CIPH_RUN;
      end
      llcr_pkg::CIPH_RUN: begin
        if (i_evt.crypt_done) st_d.ciph = llcr_pkg::CIPH_IDLE;
      end
      default: st_d.ciph = llcr_pkg::CIPH_IDLE;
    endcase
    // busy is registered so the output comes straight from a flop
    st_d.busy = (st_d.ciph != llcr_pkg::CIPH_IDLE);
    if (i_evt.crypt_late) st_d.late_err = 1'b1;
    if (i_evt.tx_mic_valid) st_d.tx_mic = i_evt.tx_mic;
    if (i_evt.rx_mic_valid) st_d.rx_mic = i_evt.rx_mic;
    if (i_evt.scan_valid) begin
      st_d.scan_scan_init_a = i_evt.scan_scan_init_a;
      st_d.scan_upper = i_evt.scan_upper;
    end
    // running tallies, published to the count registers on rf abort for each tally whose count enable is set
    if (st_q.cfg.tx_cnt_en && i_evt.tx_pkt) st_d.tx_run = st_q.tx_run + 32'h0000_0001;
    if (st_q.cfg.rx_cnt_en && i_evt.rx_pkt_ok) st_d.rx_run = st_q.rx_run + 32'h0000_0001;
    if (i_evt.rf_abort) begin
      if (st_q.cfg.tx_cnt_en) st_d.tx_tally = st_d.tx_run;
      if (st_q.cfg.rx_cnt_en) st_d.rx_tally = st_d.rx_run;
      st_d.tx_run = 32'h0000_0000;
      st_d.rx_run = 32'h0000_0000;
    end
    st_d.coarse_hit = (st_q.cfg.coarse_tgt == i_base_time_counter[26:llcr_pkg::COARSE_LSB])
      && (i_base_time_counter[3:0] == 4'h0);
    st_d.fine_hit = (st_q.cfg.fine_tgt == i_base_time_counter);
    st_d.rdata = i_rd ? read_mux(st_q, i_addr) : 32'h0000_0000;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_q <= '0;
      st_q.cfg <= cfg_reset();
      st_q.ciph <= llcr_pkg::CIPH_IDLE;
      st_q.scan_scan_init_a <= llcr_pkg::SCAN_RST;
      st_q.scan_upper <= llcr_pkg::SCAN_RST;
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  assign o_rdata = st_q.rdata;
  assign o_cfg = st_q.cfg;
  assign o_cipher_start = st_q.start_pulse;
  assign o_cipher_busy = st_q.busy;
  assign o_diag_profile = st_q.cfg.profile;
  assign o_coarse_hit = st_q.coarse_hit;
  assign o_fine_hit = st_q.fine_hit;
  assign o_payload_len = {7'h00, st_q.cfg.test_len};
  assign o_rtrip_cycles_hi = st_q.cfg.rtrip[6:2];

endmodule : llcr_regs

// ### inc/llcr_pkg.sv
// package: register map, field positions, reset values and carriers of the link control registers
package llcr_pkg;
  // register byte offsets
  localparam logic [31:0] OFS_PROFILE = 32'h4000_0064;
  localparam logic [31:0] OFS_RADIO_SEL = 32'h4000_0074;
  localparam logic [31:0] OFS_PWR_TIMING = 32'h4000_0080;
  localparam logic [31:0] OFS_ADV_MAP = 32'h4000_0090;
  localparam logic [31:0] OFS_ADV_INTERVAL = 32'h4000_00A0;
  localparam logic [31:0] OFS_SCAN_COUNTERS = 32'h4000_00A4;
  localparam logic [31:0] OFS_PUB_LIST = 32'h4000_00B0;
  localparam logic [31:0] OFS_PRIV_LIST = 32'h4000_00B4;
  localparam logic [31:0] OFS_LIST_COUNTS = 32'h4000_00B8;
  localparam logic [31:0] OFS_CIPHER_CTRL = 32'h4000_00C0;
  localparam logic [31:0] OFS_KEY0 = 32'h4000_00C4;
  localparam logic [31:0] OFS_KEY1 = 32'h4000_00C8;
  localparam logic [31:0] OFS_KEY2 = 32'h4000_00CC;
  localparam logic [31:0] OFS_KEY3 = 32'h4000_00D0;
  localparam logic [31:0] OFS_CIPHER_PTR = 32'h4000_00D4;
  localparam logic [31:0] OFS_TX_MIC = 32'h4000_00D8;
  localparam logic [31:0] OFS_RX_MIC = 32'h4000_00DC;
  localparam logic [31:0] OFS_TEST_CTRL = 32'h4000_00E0;
  localparam logic [31:0] OFS_TEST_TX_CNT = 32'h4000_00E4;
  localparam logic [31:0] OFS_TEST_RX_CNT = 32'h4000_00E8;
  localparam logic [31:0] OFS_PREFETCH = 32'h4000_00F0;
  localparam logic [31:0] OFS_COARSE_TGT = 32'h4000_00F4;
  localparam logic [31:0] OFS_FINE_TGT = 32'h4000_00F8;
  localparam logic [31:0] OFS_SAMPLE = 32'h4000_00FC;
  localparam logic [31:0] OFS_ERROR_STAT = 32'h4000_0060;
  // field positions
  localparam int RADIO_SEL_LSB = 16;
  localparam int RTRIP_LSB = 24;
  localparam int RX_POWERUP_TIME_LSB = 16;
  localparam int TX_POWERDOWN_EXTEND_LSB = 8;
  localparam int SCAN_INIT_A_LSB = 16;
  localparam int PRIV_CNT_LSB = 8;
  localparam int CIPHER_MODE_BIT = 1;
  localparam int CIPHER_START_BIT = 0;
  localparam int ENDLESS_RX_BIT = 31;
  localparam int RX_CNT_EN_BIT = 27;
  localparam int ENDLESS_TX_BIT = 15;
  localparam int LEN_SRC_BIT = 14;
  localparam int PRBS_TYPE_BIT = 13;
  localparam int PLD_SRC_BIT = 12;
  localparam int TX_CNT_EN_BIT = 11;
  localparam int EARLY_ABORT_BIT = 31;
  localparam int ABORT_LSB = 16;
  localparam int COARSE_LSB = 4;
  // reset values
  localparam logic [7:0] PWRUP_RST = 8'hD2;
  localparam logic [3:0] PWRDN_RST = 4'h3;
  localparam logic [2:0] ADV_MAP_RST = 3'h7;
  localparam logic [8:0] SCAN_RST = 9'h001;
  localparam logic [8:0] FETCH_RST = 9'h096;
  localparam logic [9:0] ABORT_RST = 10'h1FE;
  localparam logic EARLY_ABORT_RST = 1'b1;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;

  typedef enum logic [1:0] {
    CIPH_IDLE = 2'b00,
    CIPH_FETCH = 2'b01,
    CIPH_RUN = 2'b11
  } llcr_ciph_e;

  // software-programmed fields
  typedef struct packed {
    logic [31:0] profile;
    logic [4:0] radio_sel;
    logic [6:0] rtrip;
    logic [7:0] rx_pwrup;
    logic [3:0] tx_pwrdn;
    logic [7:0] tx_pwrup;
    logic [2:0] adv_map;
    logic [13:0] adv_space;
    logic [15:0] pub_start;
    logic [15:0] priv_start;
    logic [7:0] priv_cnt;
    logic [7:0] pub_cnt;
    logic cipher_mode;
    logic [127:0] key;
    logic [15:0] cipher_addr;
    logic endless_rx;
    logic rx_cnt_en;
    logic endless_tx;
    logic len_src;
    logic prbs_type;
    logic pld_src;
    logic tx_cnt_en;
    logic [8:0] test_len;
    logic early_abort;
    logic [9:0] abort_at;
    logic [8:0] fetch_at;
    logic [22:0] coarse_tgt;
    logic [26:0] fine_tgt;
  } llcr_cfg_s;

  // events from the link engine
  typedef struct packed {
    logic crypt_done;
    logic crypt_late;
    logic tx_mic_valid;
    logic [31:0] tx_mic;
    logic rx_mic_valid;
    logic [31:0] rx_mic;
    logic tx_pkt;
    logic rx_pkt_ok;
    logic rf_abort;
    logic scan_valid;
    logic [8:0] scan_scan_init_a;
    logic [8:0] scan_upper;
  } llcr_evt_s;
endpackage : llcr_pkg

// ### test/llcr_regs_properties.sv
// checker: port-level timing properties of the link control register bank
`timescale 1ns/1ns
module llcr_regs_checker (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // register port
  input wire logic i_ce,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // events, time and outputs
  input wire llcr_pkg::llcr_evt_s i_evt,
  input wire logic [26:0] i_base_time_counter,
  input wire llcr_pkg::llcr_cfg_s o_cfg,
  input wire logic [15:0] o_payload_len,
  input wire logic o_cipher_start,
  input wire logic o_cipher_busy,
  input wire logic [31:0] o_diag_profile,
  input wire logic o_coarse_hit,
  input wire logic o_fine_hit,
  input wire logic [4:0] o_rtrip_cycles_hi
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  // last cycle's write data, to check what a write left in the outputs
  logic [31:0] wdata_q;

  always_ff @(posedge i_ref_clk) begin
    wdata_q <= i_wdata;
  end

  rdata_idle_zero_a: assert property (i_ce && !i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  start_pulse_a: assert property (i_ce && i_wr && i_addr == llcr_pkg::OFS_CIPHER_CTRL
    && i_wdata[0] && !o_cipher_busy |=> o_cipher_start && o_cipher_busy ##1 !o_cipher_start)
    else $error("cipher start did not pulse once");
  busy_end_a: assert property (i_ce && o_cipher_busy && !o_cipher_start
    && i_evt.crypt_done |=> !o_cipher_busy)
    else $error("busy did not drop after completion");
  busy_hold_a: assert property (i_ce && o_cipher_busy && !i_evt.crypt_done |=> o_cipher_busy)
    else $error("busy dropped without completion");
  coarse_match_a: assert property (i_ce && i_base_time_counter[3:0] == 4'h0
    && i_base_time_counter[26:4] == o_cfg.coarse_tgt |=> o_coarse_hit)
    else $error("coarse compare missed a match");
  coarse_miss_a: assert property (i_ce && i_base_time_counter[3:0] != 4'h0 |=> !o_coarse_hit)
    else $error("coarse compare fired off the boundary");
  fine_match_a: assert property (i_ce && i_base_time_counter == o_cfg.fine_tgt |=> o_fine_hit)
    else $error("fine compare missed a match");
  fine_miss_a: assert property (i_ce && i_base_time_counter != o_cfg.fine_tgt |=> !o_fine_hit)
    else $error("fine compare fired without a match");
  diag_copy_a: assert property (i_ce && i_wr && i_addr == llcr_pkg::OFS_PROFILE |=>
    o_diag_profile == wdata_q)
    else $error("diagnostic word differs from profile");
  rtrip_copy_a: assert property (i_ce && i_wr && i_addr == llcr_pkg::OFS_PWR_TIMING |=>
    o_rtrip_cycles_hi == wdata_q[30:26])
    else $error("round trip upper bits wrong");
  payload_len_a: assert property (i_ce && i_wr && i_addr == llcr_pkg::OFS_TEST_CTRL |=>
    o_payload_len == {7'h00, wdata_q[8:0]})
    else $error("payload length wrong");
  key_word_a: assert property (i_ce && i_wr && i_addr == llcr_pkg::OFS_KEY1 |=>
    o_cfg.key[63:32] == $past(i_wdata))
    else $error("key word one not placed in bits 63:32");
endmodule : llcr_regs_checker

bind llcr_regs llcr_regs_checker u_llcr_chk (.i_ref_clk, .i_rst, .i_ce, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_evt, .i_base_time_counter, .o_cfg, .o_payload_len,
  .o_cipher_start, .o_cipher_busy, .o_diag_profile, .o_coarse_hit, .o_fine_hit,
  .o_rtrip_cycles_hi);

// ### test/tb.sv
// testbench: register map, cipher control, tallies, captured values and timer compares
`timescale 1ns/1ns
module tb;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic [31:0] i_addr = 32'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  llcr_pkg::llcr_evt_s i_evt = '0;
  logic [26:0] i_base_time_counter = 27'h0;
  llcr_pkg::llcr_cfg_s o_cfg;
  logic [15:0] o_payload_len;
  logic o_cipher_start;
  logic o_cipher_busy;
  logic o_coarse_hit;
  logic o_fine_hit;
  logic [31:0] pat [2] = '{32'hFFFF_FFFF, 32'h5A5A_A5A5};
  int n_fail = 0;
  int total_checks = 0;

  llcr_regs dut (.i_ref_clk, .i_rst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_evt, .i_base_time_counter, .o_cfg, .o_payload_len, .o_cipher_start, .o_cipher_busy,
    .o_diag_profile(), .o_coarse_hit, .o_fine_hit, .o_rtrip_cycles_hi());

  initial begin
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] adr(input int k);
    return 32'h4000_0060 + 32'(k * 4);
  endfunction : adr

  function automatic logic [31:0] exp_rst(input logic [31:0] a);
    case (a[7:0])
      8'h80: return 32'h00D2_03D2;
      8'h90: return 32'h0000_0007;
      8'hA4: return 32'h0001_0001;
      8'hF0: return 32'h81FE_0096;
      default: return 32'h0;
    endcase
  endfunction : exp_rst

  // writable bits of each address the pattern loop writes; zero means read-only, unmapped or not written by that loop
  function automatic logic [31:0] msk(input logic [31:0] a);
    case (a[7:0])
      8'h64, 8'hC4, 8'hC8, 8'hCC, 8'hD0: return 32'hFFFF_FFFF;
      8'h74: return 32'h001F_0000;
      8'h80: return 32'h7FFF_0FFF;
      8'h90: return 32'h0000_0007;
      8'hA0: return 32'h0000_3FFF;
      8'hB0, 8'hB4, 8'hB8, 8'hD4: return 32'h0000_FFFF;
      8'hE0: return 32'h8800_F9FF;
      8'hF0: return 32'h83FF_01FF;
      8'hF4: return 32'h007F_FFFF;
      8'hF8: return 32'h07FF_FFFF;
      default: return 32'h0;
    endcase
  endfunction : msk

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    chk(o_rdata, exp);
  endtask : rd

  task automatic pulse(input llcr_pkg::llcr_evt_s e);
    @(posedge i_ref_clk);
    i_evt <= e;
    @(posedge i_ref_clk);
    i_evt <= '0;
  endtask : pulse

  task automatic complete_run;
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  initial begin
    llcr_pkg::llcr_evt_s ev;
    int nf;
    int nc;
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 40; k++) rd(adr(k), exp_rst(adr(k)));
    foreach (pat[p]) begin
      // error flag, cipher control and sample register are left alone here
      for (int k = 1; k < 39; k++) if (k != 24) wr(adr(k), pat[p]);
      for (int k = 0; k < 40; k++) rd(adr(k), msk(adr(k)) == 32'h0 ? exp_rst(adr(k)) :
        pat[p] & msk(adr(k)));
      chk({16'h0, o_payload_len}, {23'h0, pat[p][8:0]});
      chk(o_cfg.key[127:96], pat[p]);
    end
    // a write while the clock enable is low must leave the register alone
    @(posedge i_ref_clk);
    i_ce <= 1'b0;
    wr(llcr_pkg::OFS_PROFILE, 32'h0F0F_0F0F);
    @(posedge i_ref_clk);
    i_ce <= 1'b1;
    rd(llcr_pkg::OFS_PROFILE, 32'h5A5A_A5A5);
    wr(llcr_pkg::OFS_RADIO_SEL, 32'h0002_0000);
    rd(llcr_pkg::OFS_RADIO_SEL, 32'h0002_0000);
    wr(llcr_pkg::OFS_CIPHER_CTRL, 32'h3);
    @(negedge i_ref_clk);
    chk({30'h0, o_cipher_start, o_cipher_busy}, 32'h3);
    wr(llcr_pkg::OFS_CIPHER_CTRL, 32'h1);
    rd(llcr_pkg::OFS_CIPHER_CTRL, 32'h2);
    ev = '0;
    ev.crypt_done = 1'b1;
    pulse(ev);
    for (nf = 0; nf < 8 && o_cipher_busy !== 1'b0; nf++) @(negedge i_ref_clk);
    if (nf == 8) begin
      n_fail++;
      complete_run();
    end
    wr(llcr_pkg::OFS_CIPHER_CTRL, 32'h1);
    rd(llcr_pkg::OFS_CIPHER_CTRL, 32'h0);
    wr(llcr_pkg::OFS_TEST_CTRL, 32'h0800_0800);
    ev = '0;
    ev.tx_pkt = 1'b1;
    repeat (2) pulse(ev);
    ev = '0;
    ev.rx_pkt_ok = 1'b1;
    repeat (3) pulse(ev);
    ev.tx_pkt = 1'b1;
    ev.rf_abort = 1'b1;
    pulse(ev);
    rd(llcr_pkg::OFS_TEST_TX_CNT, 32'h3);
    rd(llcr_pkg::OFS_TEST_RX_CNT, 32'h4);
    wr(llcr_pkg::OFS_TEST_CTRL, 32'h0800_0000);
    ev = '0;
    ev.tx_pkt = 1'b1;
    ev.rf_abort = 1'b1;
    pulse(ev);
    rd(llcr_pkg::OFS_TEST_TX_CNT, 32'h3);
    rd(llcr_pkg::OFS_TEST_RX_CNT, 32'h0);
    ev = '0;
    ev.tx_mic_valid = 1'b1;
    ev.tx_mic = 32'h1234_5678;
    ev.rx_mic_valid = 1'b1;
    ev.rx_mic = 32'h9ABC_DEF0;
    ev.scan_valid = 1'b1;
    ev.scan_scan_init_a = 9'h0AB;
    ev.scan_upper = 9'h155;
    ev.crypt_late = 1'b1;
    pulse(ev);
    rd(llcr_pkg::OFS_TX_MIC, 32'h1234_5678);
    rd(llcr_pkg::OFS_RX_MIC, 32'h9ABC_DEF0);
    rd(llcr_pkg::OFS_SCAN_COUNTERS, 32'h00AB_0155);
    rd(llcr_pkg::OFS_ERROR_STAT, 32'h1);
    wr(llcr_pkg::OFS_COARSE_TGT, 32'h3);
    wr(llcr_pkg::OFS_FINE_TGT, 32'h35);
    nf = 0;
    nc = 0;
    for (int k = 0; k < 24; k++) begin
      @(posedge i_ref_clk);
      i_base_time_counter <= 27'h2E + 27'(k);
      @(negedge i_ref_clk);
      nf += int'(o_fine_hit === 1'b1);
      nc += int'(o_coarse_hit === 1'b1);
    end
    chk(32'(nf), 32'h1);
    chk(32'(nc), 32'h1);
    // sample strobe captures the base time counter, which now rests at 0x45
    wr(llcr_pkg::OFS_SAMPLE, 32'h1);
    rd(llcr_pkg::OFS_SAMPLE, 32'h45);
    complete_run();
  end
endmodule : tb
